// ---- hw/fcp_ctrl.sv ----
// Purpose: configuration save/discard, custody protection, process control
// Assumes: one request strobe per cycle per port
// Notes:   stored copy models the non-volatile memory, no reset
`timescale 1ns/10ps
// What this block does
// RULE_01 - reload stored configuration after power-up
// RULE_02 - measurement uses settings only after save
// RULE_03 - units and scaling act immediately
// RULE_04 - unsaved flag while live differs stored
// RULE_05 - discard coil reloads stored configuration
// RULE_06 - totaliser save coils store current totals
// RULE_07 - units zero multiplies by user scale
// RULE_08 - scaling starts from fixed internal units
// RULE_09 - source register picks variable, limits bound
// RULE_10 - action: disabled, zero flow, zero plus reset
// RULE_11 - control active bit in status and input
// RULE_12 - password write enables custody, blocks marked writes
// RULE_13 - custody state readable as binary input
// RULE_14 - custody blocks clearing protected error flags
// RULE_15 - three wrong passwords lock ten minutes
// RULE_16 - flow below low threshold is dropped
// RULE_17 - suppression triggers on falling below threshold
// RULE_18 - suppression threshold added for set duration
// RULE_19 - refused writes change nothing
// RULE_20 - threshold returns to plain after period
module fcp_ctrl #(
  parameter int TICK_CYC = fcp_pkg::TICK_CYC,
  parameter int LOCK_MS  = fcp_pkg::LOCK_MS
) (
  input  wire logic               i_clk,
  input  wire logic               i_arst_n,
  input  wire logic               i_nvm_init,
  input  wire logic               i_hr_wr,
  input  wire logic               i_hr_rd,
  input  wire logic        [15:0] i_hr_addr,
  input  wire logic        [15:0] i_hr_wdata,
  input  wire logic               i_coil_wr,
  input  wire logic        [15:0] i_coil_addr,
  input  wire logic               i_coil_val,
  input  wire logic signed [15:0] i_flow,
  input  wire logic signed [15:0] i_temp,
  input  wire logic signed [15:0] i_density,
  input  wire logic        [31:0] i_mass_total,
  input  wire logic        [31:0] i_vol_total,
  output logic                    o_hr_ack,
  output logic             [7:0]  o_hr_exc,
  output logic             [15:0] o_hr_rdata,
  output logic                    o_unsaved,
  output logic                    o_custody_on,
  output logic                    o_pc_active,
  output logic             [7:0]  o_exc_status,
  output logic signed      [15:0] o_flow,
  output logic             [47:0] o_vol_total_tx,
  output logic                    o_tot_reset,
  output logic                    o_tot_load,
  output logic             [31:0] o_mass_total_ld,
  output logic             [31:0] o_vol_total_ld,
  output logic                    o_err_clr,
  output logic                    o_err_clr_ct,
  output logic                    o_sup_active
);
  // marked registers refuse writes under custody
  function automatic logic is_ct(input logic [3:0] idx);
    is_ct = (idx == fcp_pkg::IDX_PC_ACT) || (idx == fcp_pkg::IDX_PC_SRC) ||
            (idx == fcp_pkg::IDX_LOWF) || (idx == fcp_pkg::IDX_LIM_MIN) ||
            (idx == fcp_pkg::IDX_LIM_MAX) || (idx == fcp_pkg::IDX_SUP_DUR) ||
            (idx == fcp_pkg::IDX_SUP_THR);
  endfunction

  // returns {hit, index}
  function automatic logic [4:0] decode(input logic [15:0] a);
    if (a == fcp_pkg::HR_PASSWORD) begin
      decode = {1'b1, fcp_pkg::IDX_PW};
    end else if (a == fcp_pkg::HR_PC_ACT) begin
      decode = {1'b1, fcp_pkg::IDX_PC_ACT};
    end else if (a == fcp_pkg::HR_PC_SRC) begin
      decode = {1'b1, fcp_pkg::IDX_PC_SRC};
    end else if (a == fcp_pkg::HR_LOWF) begin
      decode = {1'b1, fcp_pkg::IDX_LOWF};
    end else if (a == fcp_pkg::HR_LIM_MIN) begin
      decode = {1'b1, fcp_pkg::IDX_LIM_MIN};
    end else if (a == fcp_pkg::HR_LIM_MAX) begin
      decode = {1'b1, fcp_pkg::IDX_LIM_MAX};
    end else if (a == fcp_pkg::HR_VOL_SCALE) begin
      decode = {1'b1, fcp_pkg::IDX_VOL_SCALE};
    end else if (a == fcp_pkg::HR_SUP_DUR) begin
      decode = {1'b1, fcp_pkg::IDX_SUP_DUR};
    end else if (a == fcp_pkg::HR_SUP_THR) begin
      decode = {1'b1, fcp_pkg::IDX_SUP_THR};
    end else if (a == fcp_pkg::HR_VOL_UNITS) begin
      decode = {1'b1, fcp_pkg::IDX_VOL_UNITS};
    end else begin
      decode = 5'h00;
    end
  endfunction

  logic [15:0]     live_ff [fcp_pkg::NREG];
  logic [15:0]     nxt_live [fcp_pkg::NREG];
  logic [15:0]     stored_mem [fcp_pkg::NREG];
  logic [31:0]     tot_mass_mem;
  logic [31:0]     tot_vol_mem;
  logic            load_ff;
  logic            nxt_load;
  fcp_pkg::fcp_pw_t pw_ff;
  fcp_pkg::fcp_pw_t nxt_pw;
  logic [1:0]      wrong_ff;
  logic [1:0]      nxt_wrong;
  logic [19:0]     lock_ff;
  logic [19:0]     nxt_lock;
  logic [15:0]     div_ff;
  logic [15:0]     nxt_div;
  logic            tick;
  logic            ack_ff;
  logic [7:0]      exc_ff;
  logic [7:0]      nxt_exc;
  logic [15:0]     rdata_ff;
  logic [15:0]     nxt_rdata;
  logic            unsaved_ff;
  logic            nxt_unsaved;
  logic            pc_ff;
  logic            nxt_pc;
  logic            totrst_ff;
  logic            nxt_totrst;
  logic            errclr_ff;
  logic            errclr_ct_ff;
  logic            tot_load_ff;
  logic signed [15:0] flow_ff;
  logic signed [15:0] nxt_flow;
  logic [47:0]     voltx_ff;
  logic [47:0]     nxt_voltx;
  logic signed [15:0] cut_flow;
  logic signed [15:0] pc_var;
  logic [4:0]      dec;
  logic            save_req;
  logic            coil_on;
  logic            custody;

  assign coil_on  = i_coil_wr && i_coil_val;
  assign save_req = coil_on && (i_coil_addr == fcp_pkg::COIL_SAVE);
  assign custody  = live_ff[fcp_pkg::IDX_CT_ON][0];
  assign dec      = decode(i_hr_addr);
  assign tick     = div_ff == 16'(TICK_CYC - 1);

  // stored copy: survives reset, only written by save or factory init
  always_ff @(posedge i_clk) begin
    if (i_nvm_init) begin
      for (int i = 0; i < fcp_pkg::NREG; i++) begin
        stored_mem[i] <= fcp_pkg::DEF_ZERO;
      end
      stored_mem[fcp_pkg::IDX_PC_ACT]    <= fcp_pkg::DEF_PC_ACT;
      stored_mem[fcp_pkg::IDX_LIM_MIN]   <= fcp_pkg::DEF_LIM_MIN;
      stored_mem[fcp_pkg::IDX_LIM_MAX]   <= fcp_pkg::DEF_LIM_MAX;
      stored_mem[fcp_pkg::IDX_VOL_SCALE] <= fcp_pkg::DEF_SCALE;
      stored_mem[fcp_pkg::IDX_VOL_UNITS] <= fcp_pkg::DEF_UNITS;
      tot_mass_mem <= 32'h0000_0000;
      tot_vol_mem  <= 32'h0000_0000;
    end else begin
      if (save_req) begin
        for (int i = 0; i < fcp_pkg::NREG; i++) begin
          stored_mem[i] <= live_ff[i]; // RULE_02
        end
      end
      if (coil_on && (i_coil_addr == fcp_pkg::COIL_TOT_SAVE || i_coil_addr == fcp_pkg::COIL_TOT_SV2)) begin
        tot_mass_mem <= i_mass_total; // RULE_06
        tot_vol_mem  <= i_vol_total;
      end
    end
  end

  // holding registers, password and lockout
  always_comb begin
    for (int i = 0; i < fcp_pkg::NREG; i++) begin
      nxt_live[i] = live_ff[i];
    end
    nxt_load  = load_ff;
    nxt_pw    = pw_ff;
    nxt_wrong = wrong_ff;
    nxt_lock  = lock_ff;
    nxt_exc   = fcp_pkg::EXC_NONE;
    nxt_rdata = rdata_ff;
    nxt_div   = tick ? 16'h0000 : div_ff + 16'h0001;
    if (pw_ff == fcp_pkg::PW_LOCKED && tick) begin
      if (lock_ff == 20'h00000) begin
        nxt_pw = fcp_pkg::PW_OPEN;
      end else begin
        nxt_lock = lock_ff - 20'h00001;
      end
    end
    if (coil_on && i_coil_addr == fcp_pkg::COIL_DISCARD) begin
      nxt_load = 1'b1; // RULE_05
    end
    if (load_ff) begin
      for (int i = 0; i < fcp_pkg::NREG; i++) begin
        nxt_live[i] = stored_mem[i]; // RULE_01 RULE_05
      end
      nxt_load = 1'b0;
    end else if (i_hr_wr) begin
      if (!dec[4]) begin
        nxt_exc = fcp_pkg::EXC_ILL_ADDR;
      end else if (dec[3:0] == fcp_pkg::IDX_PW) begin
        if (pw_ff == fcp_pkg::PW_LOCKED) begin
          nxt_exc = fcp_pkg::EXC_ILL_FUNC; // RULE_15 RULE_19
        end else if (!custody) begin
          nxt_live[fcp_pkg::IDX_PW]    = i_hr_wdata; // RULE_12
          nxt_live[fcp_pkg::IDX_CT_ON] = 16'h0001;
          nxt_wrong = 2'h0;
        end else if (i_hr_wdata == live_ff[fcp_pkg::IDX_PW]) begin
          nxt_live[fcp_pkg::IDX_CT_ON] = 16'h0000;
          nxt_wrong = 2'h0;
        end else if (wrong_ff == fcp_pkg::LOCK_TRIES - 2'h1) begin
          nxt_exc   = fcp_pkg::EXC_ILL_FUNC; // RULE_15
          nxt_pw    = fcp_pkg::PW_LOCKED;
          nxt_lock  = 20'(LOCK_MS - 1);
          nxt_wrong = 2'h0;
        end else begin
          nxt_exc   = fcp_pkg::EXC_ILL_FUNC;
          nxt_wrong = wrong_ff + 2'h1;
        end
      end else if (custody && is_ct(dec[3:0])) begin
        nxt_exc = fcp_pkg::EXC_ILL_FUNC; // RULE_12 RULE_19
      end else begin
        nxt_live[dec[3:0]] = i_hr_wdata;
      end
    end
    if (i_hr_rd) begin
      nxt_rdata = dec[4] ? live_ff[dec[3:0]] : 16'h0000;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int i = 0; i < fcp_pkg::NREG; i++) begin
        live_ff[i] <= 16'h0000;
      end
      load_ff  <= 1'b1;
      pw_ff    <= fcp_pkg::PW_OPEN;
      wrong_ff <= 2'h0;
      lock_ff  <= 20'h00000;
      div_ff   <= 16'h0000;
      ack_ff   <= 1'b0;
      exc_ff   <= fcp_pkg::EXC_NONE;
      rdata_ff <= 16'h0000;
    end else begin
      for (int i = 0; i < fcp_pkg::NREG; i++) begin
        live_ff[i] <= nxt_live[i];
      end
      load_ff  <= nxt_load;
      pw_ff    <= nxt_pw;
      wrong_ff <= nxt_wrong;
      lock_ff  <= nxt_lock;
      div_ff   <= nxt_div;
      ack_ff   <= i_hr_wr || i_hr_rd;
      exc_ff   <= nxt_exc;
      rdata_ff <= nxt_rdata;
    end
  end

  // measurement side: low-flow and control settings come from the stored copy, volume units and scale from the live registers
  fcp_low_flow u_low_flow (
    .i_clk        (i_clk),
    .i_arst_n     (i_arst_n),
    .i_tick       (tick),
    .i_flow       (i_flow),
    .i_thr        (stored_mem[fcp_pkg::IDX_LOWF]),
    .i_sup_thr    (stored_mem[fcp_pkg::IDX_SUP_THR]),
    .i_sup_dur    (stored_mem[fcp_pkg::IDX_SUP_DUR]),
    .o_flow       (cut_flow),
    .o_sup_active (o_sup_active)
  );

  always_comb begin
    nxt_unsaved = 1'b0;
    for (int i = 0; i < fcp_pkg::NREG; i++) begin
      if (live_ff[i] != stored_mem[i]) begin
        nxt_unsaved = 1'b1; // RULE_04
      end
    end
    pc_var = (stored_mem[fcp_pkg::IDX_PC_SRC] == fcp_pkg::PC_SRC_DENS) ? i_density : i_temp; // RULE_09
    nxt_pc = (pc_var < $signed(stored_mem[fcp_pkg::IDX_LIM_MIN]) ||
              pc_var > $signed(stored_mem[fcp_pkg::IDX_LIM_MAX])) &&
             (stored_mem[fcp_pkg::IDX_PC_ACT] == fcp_pkg::PC_ZERO ||
              stored_mem[fcp_pkg::IDX_PC_ACT] == fcp_pkg::PC_ZERO_RST); // RULE_10 RULE_11
    nxt_totrst = nxt_pc && stored_mem[fcp_pkg::IDX_PC_ACT] == fcp_pkg::PC_ZERO_RST; // RULE_10
    nxt_flow   = pc_ff ? 16'sh0000 : cut_flow; // RULE_10
    // internal unit of the volume total is cubic centimetres
    if (live_ff[fcp_pkg::IDX_VOL_UNITS] == fcp_pkg::UNITS_USER) begin
      nxt_voltx = i_vol_total * live_ff[fcp_pkg::IDX_VOL_SCALE]; // RULE_03 RULE_07 RULE_08
    end else begin
      nxt_voltx = {16'h0000, i_vol_total};
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      unsaved_ff   <= 1'b0;
      pc_ff        <= 1'b0;
      totrst_ff    <= 1'b0;
      flow_ff      <= 16'sh0000;
      voltx_ff     <= 48'h0000_0000_0000;
      errclr_ff    <= 1'b0;
      errclr_ct_ff <= 1'b0;
      tot_load_ff  <= 1'b0;
    end else begin
      unsaved_ff   <= nxt_unsaved;
      pc_ff        <= nxt_pc;
      totrst_ff    <= nxt_totrst;
      flow_ff      <= nxt_flow;
      voltx_ff     <= nxt_voltx;
      errclr_ff    <= coil_on && i_coil_addr == fcp_pkg::COIL_ERR_CLR;
      errclr_ct_ff <= coil_on && i_coil_addr == fcp_pkg::COIL_ERR_CLR && !custody; // RULE_14
      tot_load_ff  <= load_ff; // RULE_06
    end
  end

  assign o_hr_ack        = ack_ff;
  assign o_hr_exc        = exc_ff;
  assign o_hr_rdata      = rdata_ff;
  assign o_unsaved       = unsaved_ff;
  assign o_custody_on    = custody; // RULE_13
  assign o_pc_active     = pc_ff;
  assign o_exc_status    = 8'(pc_ff) << fcp_pkg::EXC_PC_BIT; // RULE_11
  assign o_flow          = flow_ff;
  assign o_vol_total_tx  = voltx_ff;
  assign o_tot_reset     = totrst_ff;
  assign o_tot_load      = tot_load_ff;
  assign o_mass_total_ld = tot_mass_mem;
  assign o_vol_total_ld  = tot_vol_mem;
  assign o_err_clr       = errclr_ff;
  assign o_err_clr_ct    = errclr_ct_ff;
endmodule

// ---- hw/fcp_low_flow.sv ----
// Purpose: low flow cut-off with pressure suppression boost
// Assumes: i_tick is a one-cycle pulse per suppression time unit
// Notes:   thresholds compare against flow magnitude
`timescale 1ns/10ps
module fcp_low_flow (
  input  wire logic               i_clk,
  input  wire logic               i_arst_n,
  input  wire logic               i_tick,
  input  wire logic signed [15:0] i_flow,
  input  wire logic        [15:0] i_thr,
  input  wire logic        [15:0] i_sup_thr,
  input  wire logic        [15:0] i_sup_dur,
  output logic signed      [15:0] o_flow,
  output logic                    o_sup_active
);
  logic        [15:0] mag;
  logic        [16:0] eff_thr;
  logic               above_ff;
  logic               nxt_above;
  logic        [15:0] sup_cnt_ff;
  logic        [15:0] nxt_sup_cnt;
  logic signed [15:0] flow_ff;
  logic signed [15:0] nxt_flow;

  always_comb begin
    mag         = i_flow[15] ? 16'(-i_flow) : 16'(i_flow);
    nxt_above   = mag >= i_thr;
    nxt_sup_cnt = sup_cnt_ff;
    if (above_ff && !nxt_above) begin
      nxt_sup_cnt = i_sup_dur; // RULE_17
    end else if (i_tick && sup_cnt_ff != 16'h0000) begin
      nxt_sup_cnt = sup_cnt_ff - 16'h0001;
    end
    // boost only while the period runs
    eff_thr  = {1'b0, i_thr} + ((sup_cnt_ff != 16'h0000) ? {1'b0, i_sup_thr} : 17'h00000); // RULE_18 RULE_20
    nxt_flow = ({1'b0, mag} < eff_thr) ? 16'sh0000 : i_flow; // RULE_16
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      above_ff   <= 1'b0;
      sup_cnt_ff <= 16'h0000;
      flow_ff    <= 16'sh0000;
    end else begin
      above_ff   <= nxt_above;
      sup_cnt_ff <= nxt_sup_cnt;
      flow_ff    <= nxt_flow;
    end
  end

  assign o_flow       = flow_ff;
  assign o_sup_active = sup_cnt_ff != 16'h0000;
endmodule

// ---- hw/fcp_pkg.sv ----
// Purpose: shared constants of the flow configuration and protection block
// Assumes: 40 MHz system clock, Modbus-level register and coil strobes
// Notes:   addresses are Modbus register numbers in hex
package fcp_pkg;
  localparam int          CLK_HZ        = 40_000_000;
  localparam int          TICK_MS       = 1;
  localparam int          TICK_CYC      = CLK_HZ / 1000 * TICK_MS;
  localparam int          LOCK_MIN      = 10;
  localparam int          LOCK_MS       = LOCK_MIN * 60 * 1000;
  localparam logic [1:0]  LOCK_TRIES    = 2'h3;

  localparam int          NREG          = 11;
  localparam logic [3:0]  IDX_PW        = 4'h0;
  localparam logic [3:0]  IDX_PC_ACT    = 4'h1;
  localparam logic [3:0]  IDX_PC_SRC    = 4'h2;
  localparam logic [3:0]  IDX_LOWF      = 4'h3;
  localparam logic [3:0]  IDX_LIM_MIN   = 4'h4;
  localparam logic [3:0]  IDX_LIM_MAX   = 4'h5;
  localparam logic [3:0]  IDX_VOL_SCALE = 4'h6;
  localparam logic [3:0]  IDX_SUP_DUR   = 4'h7;
  localparam logic [3:0]  IDX_SUP_THR   = 4'h8;
  localparam logic [3:0]  IDX_VOL_UNITS = 4'h9;
  localparam logic [3:0]  IDX_CT_ON     = 4'hA;

  localparam logic [15:0] HR_PASSWORD   = 16'h03EB;
  localparam logic [15:0] HR_PC_ACT     = 16'h03F1;
  localparam logic [15:0] HR_PC_SRC     = 16'h03F2;
  localparam logic [15:0] HR_VOL_UNITS  = 16'h03FE;
  localparam logic [15:0] HR_LOWF       = 16'h0BE7;
  localparam logic [15:0] HR_LIM_MIN    = 16'h0BEB;
  localparam logic [15:0] HR_LIM_MAX    = 16'h0BED;
  localparam logic [15:0] HR_VOL_SCALE  = 16'h0C0D;
  localparam logic [15:0] HR_SUP_DUR    = 16'h0C1D;
  localparam logic [15:0] HR_SUP_THR    = 16'h0C1F;

  localparam logic [15:0] COIL_SAVE     = 16'h03E9;
  localparam logic [15:0] COIL_ERR_CLR  = 16'h03F0;
  localparam logic [15:0] COIL_DISCARD  = 16'h03F2;
  localparam logic [15:0] COIL_TOT_SAVE = 16'h03F7;
  localparam logic [15:0] COIL_TOT_SV2  = 16'h03F8;

  localparam logic [15:0] PC_OFF        = 16'h0001;
  localparam logic [15:0] PC_ZERO       = 16'h0002;
  localparam logic [15:0] PC_ZERO_RST   = 16'h0003;
  localparam logic [15:0] PC_SRC_DENS   = 16'h0001;
  localparam logic [15:0] UNITS_USER    = 16'h0000;

  localparam logic [7:0]  EXC_NONE      = 8'h00;
  localparam logic [7:0]  EXC_ILL_FUNC  = 8'h01;
  localparam logic [7:0]  EXC_ILL_ADDR  = 8'h02;
  localparam int          EXC_PC_BIT    = 3;

  // factory defaults of the stored copy
  localparam logic [15:0] DEF_PC_ACT    = 16'h0001;
  localparam logic [15:0] DEF_ZERO      = 16'h0000;
  localparam logic [15:0] DEF_LIM_MAX   = 16'h7FFF;
  localparam logic [15:0] DEF_LIM_MIN   = 16'h8000;
  localparam logic [15:0] DEF_SCALE     = 16'h0001;
  localparam logic [15:0] DEF_UNITS     = 16'h0001;

  typedef enum logic [0:0] {
    PW_OPEN   = 1'b0,
    PW_LOCKED = 1'b1
  } fcp_pw_t;
endpackage

// ---- verif/fcp_ctrl_checker.sv ----
// Purpose: port assertions for the configuration and protection block
// Assumes: one clock, one request at a time
// Notes:   measurement timing is left to the bench
`timescale 1ns/10ps
module fcp_ctrl_checker (
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_hr_wr,
  input  wire logic [15:0] i_hr_addr,
  input  wire logic        i_coil_wr,
  input  wire logic [15:0] i_coil_addr,
  input  wire logic        i_coil_val,
  input  wire logic        o_hr_ack,
  input  wire logic [7:0]  o_hr_exc,
  input  wire logic        o_unsaved,
  input  wire logic        o_custody_on,
  input  wire logic        o_pc_active,
  input  wire logic [7:0]  o_exc_status,
  input  wire logic        o_tot_reset,
  input  wire logic        o_tot_load,
  input  wire logic        o_err_clr,
  input  wire logic        o_err_clr_ct
);
  logic marked;
  assign marked = i_hr_addr inside {fcp_pkg::HR_PC_ACT, fcp_pkg::HR_PC_SRC, fcp_pkg::HR_LOWF, fcp_pkg::HR_LIM_MIN,
                                    fcp_pkg::HR_LIM_MAX, fcp_pkg::HR_SUP_DUR, fcp_pkg::HR_SUP_THR};
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);
  sequence s_ct_wr;
    i_hr_wr && o_custody_on && marked;
  endsequence
  sequence s_coil(logic [15:0] a);
    i_coil_wr && i_coil_val && (i_coil_addr == a);
  endsequence
  property p_ct_refuse;
    s_ct_wr |=> o_hr_ack && (o_hr_exc == fcp_pkg::EXC_ILL_FUNC);
  endproperty
  a_ct_refuse: assert property (p_ct_refuse) else $error("protected write not refused");
  property p_ct_keep;
    s_ct_wr |=> ##1 $stable(o_unsaved);
  endproperty
  a_ct_keep: assert property (p_ct_keep) else $error("refused write moved unsaved flag");
  property p_pw_arm;
    i_hr_wr && (i_hr_addr == fcp_pkg::HR_PASSWORD) && !o_custody_on |=> o_custody_on && (o_hr_exc == 8'h00);
  endproperty
  a_pw_arm: assert property (p_pw_arm) else $error("custody not armed");
  property p_save;
    s_coil(fcp_pkg::COIL_SAVE) ##0 !i_hr_wr |=> ##1 !o_unsaved;
  endproperty
  a_save: assert property (p_save) else $error("save left unsaved flag set");
  property p_discard;
    s_coil(fcp_pkg::COIL_DISCARD) |-> ##[1:2] o_tot_load;
  endproperty
  a_discard: assert property (p_discard) else $error("discard gave no reload");
  property p_pc_bit;
    o_pc_active [*2] |-> o_exc_status[fcp_pkg::EXC_PC_BIT];
  endproperty
  a_pc_bit: assert property (p_pc_bit) else $error("status bit missing");
  property p_tot_rst;
    o_tot_reset |-> (o_pc_active || $past(o_pc_active));
  endproperty
  a_tot_rst: assert property (p_tot_rst) else $error("totals reset without control");
  property p_err_ct;
    s_coil(fcp_pkg::COIL_ERR_CLR) ##0 o_custody_on |=> o_err_clr && !o_err_clr_ct;
  endproperty
  a_err_ct: assert property (p_err_ct) else $error("protected clear under custody");
  property p_err_open;
    s_coil(fcp_pkg::COIL_ERR_CLR) ##0 !o_custody_on |=> o_err_clr && o_err_clr_ct;
  endproperty
  a_err_open: assert property (p_err_open) else $error("flag clear missing");
endmodule

bind fcp_ctrl fcp_ctrl_checker u_chk (
  .i_clk, .i_arst_n, .i_hr_wr, .i_hr_addr, .i_coil_wr, .i_coil_addr, .i_coil_val, .o_hr_ack, .o_hr_exc,
  .o_unsaved, .o_custody_on, .o_pc_active, .o_exc_status, .o_tot_reset, .o_tot_load, .o_err_clr, .o_err_clr_ct
);

// ---- verif/fcp_ctrl_tb.sv ----
// Purpose: bench for the configuration and protection block
// Assumes: short tick and lockout parameters
// Notes:   factory init pulse seeds the stored copy in reset
`timescale 1ns/10ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module fcp_ctrl_tb;
  typedef struct {logic wr; logic [15:0] a; logic [15:0] d; logic [7:0] exc; logic [15:0] rd;} fcp_row_t;
  logic               i_clk, i_arst_n, i_nvm_init, i_hr_wr, i_hr_rd, i_coil_wr, i_coil_val;
  logic        [15:0] i_hr_addr, i_hr_wdata, i_coil_addr, o_hr_rdata, keep;
  logic signed [15:0] i_flow, i_temp, i_density, o_flow;
  logic        [31:0] i_mass_total, i_vol_total, o_mass_total_ld, o_vol_total_ld;
  logic               o_hr_ack, o_unsaved, o_custody_on, o_pc_active, o_tot_reset, o_tot_load;
  logic               o_err_clr, o_err_clr_ct, o_sup_active;
  logic        [7:0]  o_hr_exc, o_exc_status;
  logic        [47:0] o_vol_total_tx;
  int                 n_mismatch = 0;
  int                 cmp_count = 0;
  int                 cyc_cnt = 0;
  fcp_row_t rows [9] = '{
    '{1'b1, fcp_pkg::HR_LOWF, 16'h000A, 8'h00, 16'h0000},
    '{1'b0, fcp_pkg::HR_LOWF, 16'h0000, 8'h00, 16'h000A},
    '{1'b1, fcp_pkg::HR_VOL_UNITS, 16'h0000, 8'h00, 16'h0000},
    '{1'b1, fcp_pkg::HR_VOL_SCALE, 16'h0003, 8'h00, 16'h0000},
    '{1'b0, fcp_pkg::HR_VOL_SCALE, 16'h0000, 8'h00, 16'h0003},
    '{1'b1, 16'h1234, 16'h0055, 8'h02, 16'h0000},
    '{1'b0, 16'h1234, 16'h0000, 8'h00, 16'h0000},
    '{1'b0, fcp_pkg::HR_PC_ACT, 16'h0000, 8'h00, 16'h0001},
    '{1'b0, fcp_pkg::HR_LIM_MAX, 16'h0000, 8'h00, 16'h7FFF}};
  fcp_master M (.i_clk, .o_hr_wr(i_hr_wr), .o_hr_rd(i_hr_rd), .o_hr_addr(i_hr_addr), .o_hr_wdata(i_hr_wdata),
    .o_coil_wr(i_coil_wr), .o_coil_addr(i_coil_addr), .o_coil_val(i_coil_val), .i_hr_ack(o_hr_ack),
    .i_hr_exc(o_hr_exc), .i_hr_rdata(o_hr_rdata));
  fcp_ctrl #(.TICK_CYC(4), .LOCK_MS(5)) DUT (.i_clk, .i_arst_n, .i_nvm_init, .i_hr_wr, .i_hr_rd, .i_hr_addr,
    .i_hr_wdata, .i_coil_wr, .i_coil_addr, .i_coil_val, .i_flow, .i_temp, .i_density, .i_mass_total, .i_vol_total,
    .o_hr_ack, .o_hr_exc, .o_hr_rdata, .o_unsaved, .o_custody_on, .o_pc_active, .o_exc_status, .o_flow,
    .o_vol_total_tx, .o_tot_reset, .o_tot_load, .o_mass_total_ld, .o_vol_total_ld, .o_err_clr, .o_err_clr_ct,
    .o_sup_active);
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic w(input logic [15:0] a, input logic [15:0] d);
    M.hr(1'b1, a, d);
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge i_clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 3000) begin
      n_mismatch++;
      close_out();
    end
  end
  initial begin
    {i_arst_n, i_nvm_init} = 2'h0;
    {i_flow, i_temp, i_density} = {16'h0005, 16'h0014, 16'h0000};
    {i_mass_total, i_vol_total} = {32'h0000004D, 32'h00000064};
    tick(2);
    i_nvm_init <= 1'b1;
    tick(1);
    i_nvm_init <= 1'b0;
    repeat (17) @(posedge i_clk);
    i_arst_n <= 1'b1;
    tick(3);
    `CHK("unsaved", 1'b0, o_unsaved)
    foreach (rows[k]) begin
      M.hr(rows[k].wr, rows[k].a, rows[k].d);
      `CHK("ack", 1'b1, M.ack_seen)
      `CHK("exc", rows[k].exc, M.exc)
      if (!rows[k].wr) `CHK("rdata", rows[k].rd, M.rdata)
    end
    `CHK("unsaved", 1'b1, o_unsaved)
    `CHK("vol_tx", 48'h00000000012C, o_vol_total_tx)
    `CHK("flow", 16'h0005, o_flow)
    M.coil(fcp_pkg::COIL_SAVE);
    tick(2);
    `CHK("unsaved", 1'b0, o_unsaved)
    `CHK("flow", 16'h0000, o_flow)
    w(fcp_pkg::HR_LOWF, 16'h0014);
    M.coil(fcp_pkg::COIL_TOT_SAVE);
    M.coil(fcp_pkg::COIL_DISCARD);
    M.hr(1'b0, fcp_pkg::HR_LOWF, 16'h0000);
    `CHK("lowf", 16'h000A, M.rdata)
    `CHK("unsaved", 1'b0, o_unsaved)
    `CHK("mass_ld", 32'h0000004D, o_mass_total_ld)
    @(posedge i_clk);
    i_mass_total <= 32'h00000058;
    M.coil(fcp_pkg::COIL_TOT_SV2);
    @(posedge i_clk);
    i_arst_n <= 1'b0;
    tick(3);
    i_arst_n <= 1'b1;
    tick(3);
    M.hr(1'b0, fcp_pkg::HR_LOWF, 16'h0000);
    `CHK("lowf", 16'h000A, M.rdata)
    `CHK("mass_ld", 32'h00000058, o_mass_total_ld)
    `CHK("vol_ld", 32'h00000064, o_vol_total_ld)
    `CHK("vol_tx", 48'h00000000012C, o_vol_total_tx)
    w(fcp_pkg::HR_PC_SRC, 16'h0000);
    w(fcp_pkg::HR_LIM_MIN, 16'hFFF6);
    w(fcp_pkg::HR_LIM_MAX, 16'h0032);
    @(posedge i_clk);
    {i_flow, i_temp} <= {16'h0028, 16'h0064};
    for (int act = 1; act <= 3; act++) begin
      w(fcp_pkg::HR_PC_ACT, act[15:0]);
      M.coil(fcp_pkg::COIL_SAVE);
      tick(4);
      `CHK("pc", act != 1, o_pc_active)
      `CHK("flow", (act == 1) ? 16'h0028 : 16'h0000, o_flow)
      `CHK("tot_rst", act == 3, o_tot_reset)
    end
    @(posedge i_clk);
    i_temp <= 16'h0014;
    tick(4);
    `CHK("pc", 1'b0, o_pc_active)
    w(fcp_pkg::HR_PC_SRC, 16'h0001);
    M.coil(fcp_pkg::COIL_SAVE);
    @(posedge i_clk);
    i_density <= 16'hFF9C;
    tick(4);
    `CHK("pc", 1'b1, o_pc_active)
    `CHK("exc_st", 1'b1, o_exc_status[fcp_pkg::EXC_PC_BIT])
    w(fcp_pkg::HR_PC_ACT, 16'h0001);
    w(fcp_pkg::HR_SUP_THR, 16'h0005);
    w(fcp_pkg::HR_SUP_DUR, 16'h0005);
    M.coil(fcp_pkg::COIL_SAVE);
    tick(4);
    `CHK("sup", 1'b0, o_sup_active)
    @(posedge i_clk);
    i_flow <= 16'h0008;
    @(posedge i_clk);
    i_flow <= 16'h000C;
    tick(4);
    `CHK("sup", 1'b1, o_sup_active)
    `CHK("flow", 16'h0000, o_flow)
    tick(30);
    `CHK("sup", 1'b0, o_sup_active)
    `CHK("flow", 16'h000C, o_flow)
    M.coil(fcp_pkg::COIL_ERR_CLR);
    w(fcp_pkg::HR_PASSWORD, 16'h1234);
    `CHK("exc", 8'h00, M.exc)
    `CHK("custody", 1'b1, o_custody_on)
    keep = {15'h0000, o_unsaved};
    w(fcp_pkg::HR_LOWF, 16'h0063);
    `CHK("exc", 8'h01, M.exc)
    `CHK("unsaved", keep[0], o_unsaved)
    M.hr(1'b0, fcp_pkg::HR_LOWF, 16'h0000);
    `CHK("lowf", 16'h000A, M.rdata)
    M.coil(fcp_pkg::COIL_ERR_CLR);
    for (int k = 0; k < 3; k++) begin
      w(fcp_pkg::HR_PASSWORD, 16'h1111);
      `CHK("exc", 8'h01, M.exc)
    end
    w(fcp_pkg::HR_PASSWORD, 16'h1234);
    `CHK("exc", 8'h01, M.exc)
    `CHK("custody", 1'b1, o_custody_on)
    // lockout 5 ticks of 4, wait twice
    tick(40);
    w(fcp_pkg::HR_PASSWORD, 16'h1234);
    `CHK("exc", 8'h00, M.exc)
    `CHK("custody", 1'b0, o_custody_on)
    close_out();
  end
endmodule

// ---- verif/fcp_master.sv ----
// Purpose: bus master stand-in issuing register and coil requests
// Assumes: requests launched just after a rising edge, one at a time
// Notes:   released address and data lines show inverted values, strobes and coil value go low
`timescale 1ns/10ps
module fcp_master (
  input  wire logic        i_clk,
  output logic             o_hr_wr,
  output logic             o_hr_rd,
  output logic      [15:0] o_hr_addr,
  output logic      [15:0] o_hr_wdata,
  output logic             o_coil_wr,
  output logic      [15:0] o_coil_addr,
  output logic             o_coil_val,
  input  wire logic        i_hr_ack,
  input  wire logic [7:0]  i_hr_exc,
  input  wire logic [15:0] i_hr_rdata
);
  logic        ack_seen;
  logic [7:0]  exc;
  logic [15:0] rdata;
  initial begin
    {o_hr_wr, o_hr_rd, o_coil_wr, o_coil_val, o_hr_addr, o_hr_wdata, o_coil_addr} = 52'h0;
  end
  task automatic hr(input logic wr, input logic [15:0] a, input logic [15:0] d);
    @(posedge i_clk);
    {o_hr_wr, o_hr_rd, o_hr_addr, o_hr_wdata} <= {wr, !wr, a, d};
    @(posedge i_clk);
    {o_hr_wr, o_hr_rd, o_hr_addr, o_hr_wdata} <= {2'h0, ~a, ~d};
    // exc stands one cycle
    #1;
    {ack_seen, exc, rdata} = {i_hr_ack, i_hr_exc, i_hr_rdata};
    repeat (2) @(posedge i_clk);
    #1;
  endtask
  task automatic coil(input logic [15:0] a);
    @(posedge i_clk);
    {o_coil_wr, o_coil_addr, o_coil_val} <= {1'b1, a, 1'b1};
    @(posedge i_clk);
    {o_coil_wr, o_coil_addr, o_coil_val} <= {1'b0, ~a, 1'b0};
    repeat (2) @(posedge i_clk);
    #1;
  endtask
endmodule
